// ==== lsd_top.sv ====
// Per-link loss-of-signal detector with APB register slave
//
// Our own choice: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "lsd_map.svh"
module lsd_top
  import lsd_pkg::*;
#(
  parameter int RUN_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_bit_valid,
  input wire logic rx_amp_below,
  input wire logic rx_amp_above,
  input wire logic rx_mark,
  output logic [4:0] amplitude_threshold_sel,
  output logic rx_data_out,
  output logic rx_data_valid_out,
  output logic signal_lost,
  output logic irq_n
);
  // Software-visible control
  logic e1_mode_ff;
  logic [4:0] thr_sel_ff;
  logic criterion_select_ff;
  logic raise_ff;
  logic signal_lost_irq_enable_ff;
  logic signal_lost_edge_select_ff;

  // Bus slave state
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff;
  logic [7:0] idx;
  logic setup_ph, wr_acc, hit;
  logic [31:0] rd_val;
  logic clr_pulse;

  // Detector state
  lsd_state_t state_ff, nxt_state;
  logic [RUN_W-1:0] run_ff, nxt_run, run_limit;
  logic rx_data_ff, rx_valid_ff;
  logic dens_done, dens_pass;
  logic [7:0] win_len, min_marks, zero_lim;
  logic signal_lost_irq_flag;
  logic irq_n_w;
  logic signal_lost_state;

  assign signal_lost_state = (state_ff == LSD_SIG_LOST);

  // Word index from byte address bits 9:2, the two low bits are ignored
  assign idx = paddr[9:2];
  assign setup_ph = psel & ~penable;
  assign wr_acc = psel & penable & pready_ff & pwrite;

  // Read mux and decode; reserved bits read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    hit = 1'b1;
    case (idx)
      `LSD_IDX_RX_MODE: rd_val[`LSD_BIT_E1_MODE] = e1_mode_ff;
      `LSD_IDX_RX_CFG1: rd_val[`LSD_THR_MSB:0] = thr_sel_ff;
      `LSD_IDX_MAINT1: begin
        rd_val[`LSD_BIT_CRIT] = criterion_select_ff;
        rd_val[`LSD_BIT_RAISE] = raise_ff;
      end
      `LSD_IDX_IRQ_EN0: rd_val[`LSD_BIT_SIGLOST] = signal_lost_irq_enable_ff;
      `LSD_IDX_IRQ_EDGE: rd_val[`LSD_BIT_SIGLOST] = signal_lost_edge_select_ff;
      `LSD_IDX_LINE_ST0: rd_val[`LSD_BIT_SIGLOST] = signal_lost_state;
      `LSD_IDX_IRQ_ST0: rd_val[`LSD_BIT_SIGLOST] = signal_lost_irq_flag;
      `LSD_IDX_IRQ_CLR0: rd_val = 32'h0000_0000; // Write-only, reads zero
      default: hit = 1'b0;
    endcase
  end

  // No wait state: answer is prepared in the setup cycle, so every bus output is a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= setup_ph;
      pslverr_ff <= setup_ph & ~hit;
      prdata_ff <= (setup_ph & ~pwrite & hit) ? rd_val : 32'h0000_0000;
    end
  end

  // Control registers, written at the access edge only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      e1_mode_ff <= `LSD_RST_BIT;
      thr_sel_ff <= `LSD_RST_THR;
      criterion_select_ff <= `LSD_RST_BIT;
      raise_ff <= `LSD_RST_BIT;
      signal_lost_irq_enable_ff <= `LSD_RST_BIT;
      signal_lost_edge_select_ff <= `LSD_RST_BIT;
    end else if (wr_acc) begin
      case (idx)
        `LSD_IDX_RX_MODE: e1_mode_ff <= pwdata[`LSD_BIT_E1_MODE];
        `LSD_IDX_RX_CFG1: thr_sel_ff <= pwdata[`LSD_THR_MSB:0];
        `LSD_IDX_MAINT1: begin
          criterion_select_ff <= pwdata[`LSD_BIT_CRIT];
          raise_ff <= pwdata[`LSD_BIT_RAISE];
        end
        `LSD_IDX_IRQ_EN0: signal_lost_irq_enable_ff <= pwdata[`LSD_BIT_SIGLOST];
        `LSD_IDX_IRQ_EDGE: signal_lost_edge_select_ff <= pwdata[`LSD_BIT_SIGLOST];
        default: ;
      endcase
    end
  end

  // Clear pulse for the sticky flag, write one to clear
  assign clr_pulse = wr_acc & (idx == `LSD_IDX_IRQ_CLR0) & pwdata[`LSD_BIT_SIGLOST];

  // Declare run length for the active mode and criterion
  always_comb begin
    case ({e1_mode_ff, criterion_select_ff})
      2'b00: run_limit = RUN_W'(`LSD_RUN_T1_ANSI);
      2'b01: run_limit = RUN_W'(`LSD_RUN_T1_I431);
      2'b10: run_limit = RUN_W'(`LSD_RUN_E1_G775);
      default: run_limit = RUN_W'(`LSD_RUN_E1_I431);
    endcase
  end

  // Density window shape depends on line mode only
  always_comb begin
    if (e1_mode_ff) begin
      win_len = `LSD_WIN_E1;
      min_marks = `LSD_MARKS_E1;
      zero_lim = `LSD_ZRUN_E1;
    end else begin
      win_len = `LSD_WIN_T1;
      min_marks = `LSD_MARKS_T1;
      zero_lim = `LSD_ZRUN_T1;
    end
  end

  // Low-amplitude run counter; saturates so a late criterion change cannot wrap it
  always_comb begin
    nxt_run = run_ff;
    if (state_ff == LSD_SIG_LOST) begin
      nxt_run = '0;
    end else if (rx_bit_valid) begin
      if (!rx_amp_below) begin
        nxt_run = '0;
      end else if (run_ff < run_limit) begin
        nxt_run = run_ff + RUN_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_ff <= '0;
    end else begin
      run_ff <= nxt_run;
    end
  end

  // Declare on amplitude run, clear on amplitude plus density together
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      LSD_SIG_OK: begin
        if (nxt_run >= run_limit) begin
          nxt_state = LSD_SIG_LOST;
        end
      end
      LSD_SIG_LOST: begin
        if (dens_done && dens_pass) begin
          nxt_state = LSD_SIG_OK;
        end
      end
      default: nxt_state = LSD_SIG_OK;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= LSD_SIG_OK;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Clearing checker, held idle while the signal is good so each search starts on a fresh block
  lsd_density u_density (
    .pclk(pclk),
    .presetn(presetn),
    .restart(state_ff == LSD_SIG_OK),
    .bit_valid(rx_bit_valid),
    .mark(rx_mark),
    .amp_ok(rx_amp_above),
    .win_len(win_len),
    .min_marks(min_marks),
    .zero_lim(zero_lim),
    .done(dens_done),
    .pass(dens_pass)
  );

  // Edge-selected interrupt
  lsd_irq u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .state(signal_lost_state),
    .edge_sel(signal_lost_edge_select_ff),
    .enable(signal_lost_irq_enable_ff),
    .clear(clr_pulse),
    .flag(signal_lost_irq_flag),
    .irq_n(irq_n_w)
  );

  // Received data path, forced to ones while lost if insertion is on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data_ff <= 1'b0;
      rx_valid_ff <= 1'b0;
    end else begin
      rx_valid_ff <= rx_bit_valid;
      rx_data_ff <= rx_mark | (signal_lost_state & raise_ff);
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign amplitude_threshold_sel = thr_sel_ff;
  assign rx_data_out = rx_data_ff;
  assign rx_data_valid_out = rx_valid_ff;
  assign signal_lost = (state_ff == LSD_SIG_LOST);
  assign irq_n = irq_n_w;

  // Checks
  sequence s_last_low_bit;
    (state_ff == LSD_SIG_OK) && rx_bit_valid && rx_amp_below && (run_ff == run_limit - RUN_W'(1));
  endsequence

  property p_declare;
    @(posedge pclk) disable iff (!presetn)
    s_last_low_bit |=> signal_lost;
  endproperty
  a_declare: assert property (p_declare) else $error("run complete but not declared");

  property p_run_restart;
    @(posedge pclk) disable iff (!presetn)
    (rx_bit_valid && !rx_amp_below) |=> (run_ff == '0) && !$rose(signal_lost);
  endproperty
  a_run_restart: assert property (p_run_restart) else $error("run not restarted");

  property p_t1_limits;
    @(posedge pclk) disable iff (!presetn)
    !e1_mode_ff |-> run_limit == (criterion_select_ff ? `LSD_RUN_T1_I431 : `LSD_RUN_T1_ANSI);
  endproperty
  a_t1_limits: assert property (p_t1_limits) else $error("wrong T1 run length");

  property p_e1_limits;
    @(posedge pclk) disable iff (!presetn)
    e1_mode_ff |-> run_limit == (criterion_select_ff ? `LSD_RUN_E1_I431 : `LSD_RUN_E1_G775);
  endproperty
  a_e1_limits: assert property (p_e1_limits) else $error("wrong E1 run length");

  property p_clear;
    @(posedge pclk) disable iff (!presetn)
    (signal_lost && dens_done && dens_pass) |=> !signal_lost;
  endproperty
  a_clear: assert property (p_clear) else $error("density passed but not cleared");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    (signal_lost && !(dens_done && dens_pass)) |=> signal_lost;
  endproperty
  a_hold: assert property (p_hold) else $error("cleared without density pass");

  sequence s_lost_raise_bit;
    signal_lost_state && raise_ff && rx_bit_valid;
  endsequence

  property p_all_ones;
    @(posedge pclk) disable iff (!presetn)
    s_lost_raise_bit |=> rx_data_valid_out && rx_data_out;
  endproperty
  a_all_ones: assert property (p_all_ones) else $error("all ones not inserted");

  property p_status_read;
    @(posedge pclk) disable iff (!presetn)
    (setup_ph && !pwrite && idx == `LSD_IDX_LINE_ST0) |=> prdata[0] == $past(signal_lost_state);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read mismatch");

  property p_irq_path;
    @(posedge pclk) disable iff (!presetn)
    (signal_lost_irq_flag && signal_lost_irq_enable_ff) |=> !irq_n;
  endproperty
  a_irq_path: assert property (p_irq_path) else $error("interrupt not reported");
endmodule
`default_nettype wire

// ==== lsd_map.svh ====
// Register map, field positions, reset values and detection counts of the loss-of-signal detector
`ifndef LSD_MAP_SVH
`define LSD_MAP_SVH

// Register indexes; byte address is four times the index
`define LSD_IDX_RX_MODE 8'h28
`define LSD_IDX_RX_CFG1 8'h29
`define LSD_IDX_MAINT1 8'h2c
`define LSD_IDX_IRQ_EN0 8'h33
`define LSD_IDX_IRQ_EDGE 8'h35
`define LSD_IDX_LINE_ST0 8'h36
`define LSD_IDX_IRQ_ST0 8'h3a
`define LSD_IDX_IRQ_CLR0 8'h3e

// Field positions
`define LSD_BIT_E1_MODE 0
`define LSD_BIT_CRIT 0
`define LSD_BIT_RAISE 1
`define LSD_BIT_SIGLOST 0
`define LSD_THR_MSB 4

// Reset values
`define LSD_RST_THR 5'h00
`define LSD_RST_BIT 1'b0

// Declare run lengths in bit intervals
`define LSD_RUN_T1_ANSI 12'd175
`define LSD_RUN_T1_I431 12'd1544
`define LSD_RUN_E1_G775 12'd32
`define LSD_RUN_E1_I431 12'd2048

// Hopping window parameters
`define LSD_WIN_T1 8'd128
`define LSD_WIN_E1 8'd32
`define LSD_MARKS_T1 8'd16
`define LSD_MARKS_E1 8'd4
`define LSD_ZRUN_T1 8'd100
`define LSD_ZRUN_E1 8'd16

`endif

// ==== lsd_pkg.sv ====
// Types shared by the loss-of-signal detector modules
package lsd_pkg;
  typedef enum logic {LSD_SIG_OK, LSD_SIG_LOST} lsd_state_t;
endpackage

// ==== lsd_density.sv ====
// Hopping-window mark density and amplitude checker used for clearing loss of signal
`timescale 1ns/1ns
`default_nettype none
module lsd_density
  import lsd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic restart,
  input wire logic bit_valid,
  input wire logic mark,
  input wire logic amp_ok,
  input wire logic [7:0] win_len,
  input wire logic [7:0] min_marks,
  input wire logic [7:0] zero_lim,
  output logic done,
  output logic pass
);
  logic [7:0] bit_cnt_ff, mark_cnt_ff, zrun_ff;
  logic bad_ff, done_ff, pass_ff;
  logic [7:0] nxt_mark_cnt, nxt_zrun;
  logic nxt_bad, last_bit;

  // Per-bit updates of the current block
  always_comb begin
    nxt_mark_cnt = mark_cnt_ff + {7'h00, mark};
    nxt_zrun = mark ? 8'h00 : ((zrun_ff == 8'hff) ? zrun_ff : zrun_ff + 8'h01);
    nxt_bad = bad_ff | (nxt_zrun >= zero_lim) | ~amp_ok;
    last_bit = (bit_cnt_ff == win_len - 8'h01);
  end

  // Whole block judged at its last bit, then thrown away either way
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_ff <= 8'h00;
      mark_cnt_ff <= 8'h00;
      zrun_ff <= 8'h00;
      bad_ff <= 1'b0;
    end else if (restart || (bit_valid && last_bit)) begin
      bit_cnt_ff <= 8'h00;
      mark_cnt_ff <= 8'h00;
      zrun_ff <= 8'h00;
      bad_ff <= 1'b0;
    end else if (bit_valid) begin
      bit_cnt_ff <= bit_cnt_ff + 8'h01;
      mark_cnt_ff <= nxt_mark_cnt;
      zrun_ff <= nxt_zrun;
      bad_ff <= nxt_bad;
    end
  end

  // One-cycle verdict pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_ff <= 1'b0;
      pass_ff <= 1'b0;
    end else begin
      done_ff <= ~restart & bit_valid & last_bit;
      pass_ff <= ~restart & bit_valid & last_bit & ~nxt_bad & (nxt_mark_cnt >= min_marks);
    end
  end

  assign done = done_ff;
  assign pass = pass_ff;

  property p_hop_restart;
    @(posedge pclk) disable iff (!presetn)
    (!restart && bit_valid && last_bit) |=> (bit_cnt_ff == 8'h00) && (mark_cnt_ff == 8'h00) && done;
  endproperty
  a_hop_restart: assert property (p_hop_restart) else $error("window did not hop");

  property p_pass_needs_marks;
    @(posedge pclk) disable iff (!presetn)
    (!restart && bit_valid && last_bit && (nxt_mark_cnt < min_marks)) |=> !pass;
  endproperty
  a_pass_needs_marks: assert property (p_pass_needs_marks) else $error("pass with few marks");
endmodule
`default_nettype wire

// ==== lsd_irq.sv ====
// Edge-selected sticky interrupt flag and active-low interrupt output
`timescale 1ns/1ns
`default_nettype none
module lsd_irq
  import lsd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic state,
  input wire logic edge_sel,
  input wire logic enable,
  input wire logic clear,
  output logic flag,
  output logic irq_n
);
  logic state_d_ff, flag_ff, irq_n_ff;
  logic set_evt;

  // Rising edge always counts, falling edge only when selected
  assign set_evt = (state & ~state_d_ff) | (edge_sel & ~state & state_d_ff);

  // Set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_d_ff <= 1'b0;
      flag_ff <= 1'b0;
      irq_n_ff <= 1'b1;
    end else begin
      state_d_ff <= state;
      flag_ff <= set_evt | (flag_ff & ~clear);
      irq_n_ff <= ~(flag_ff & enable);
    end
  end

  assign flag = flag_ff;
  assign irq_n = irq_n_ff;

  property p_rise_sets;
    @(posedge pclk) disable iff (!presetn)
    $rose(state) |=> flag;
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("rising edge missed");

  // Without edge select a falling status edge must leave the flag alone
  property p_fall_edge_sel;
    @(posedge pclk) disable iff (!presetn)
    ($fell(state) && !edge_sel && !clear) |=> flag == $past(flag);
  endproperty
  a_fall_edge_sel: assert property (p_fall_edge_sel) else $error("falling edge set the flag");

  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
    (flag && enable) |=> !irq_n;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq not asserted");
endmodule
`default_nettype wire

// ==== lsd_fe_model.sv ====
// Behavioural line front end feeding amplitude flags and sliced marks per bit interval
`timescale 1ns/1ns
`default_nettype none
module lsd_fe_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [11:0] count,
  input wire logic low,
  input wire logic slow,
  input wire logic [31:0] pattern,
  output logic busy,
  output logic rx_bit_valid,
  output logic rx_amp_below,
  output logic rx_amp_above,
  output logic rx_mark
);
  logic [11:0] left_ff;
  logic [4:0] pos_ff;
  logic gap_ff;
  assign busy = (left_ff != 12'h000);
  // Idle lines toggle so the detector cannot lean on a stale level between strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_ff <= 12'h000;
      pos_ff <= 5'h00;
      gap_ff <= 1'b0;
      rx_bit_valid <= 1'b0;
      rx_amp_below <= 1'b0;
      rx_amp_above <= 1'b0;
      rx_mark <= 1'b0;
    end else if (start) begin
      left_ff <= count;
      pos_ff <= 5'h00;
      gap_ff <= 1'b0;
      rx_bit_valid <= 1'b0;
    end else if (busy && !gap_ff) begin
      rx_bit_valid <= 1'b1;
      rx_amp_below <= low;
      rx_amp_above <= !low;
      rx_mark <= pattern[pos_ff];
      pos_ff <= pos_ff + 5'h01;
      left_ff <= left_ff - 12'h001;
      gap_ff <= slow;
    end else begin
      rx_bit_valid <= 1'b0;
      rx_amp_below <= ~rx_amp_below;
      rx_amp_above <= ~rx_amp_above;
      rx_mark <= ~rx_mark;
      gap_ff <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== lsd_top_tb.sv ====
// Self-checking bench for the loss-of-signal detector over APB and the front-end model
`timescale 1ns/1ns
`default_nettype none
`include "lsd_map.svh"
module lsd_top_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_n, signal_lost;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rd, pat;
  logic [4:0] thr;
  logic vld, below, above, mark, dout, dvalid, start, low, slow, fe_busy, last_err, last_out;
  logic [11:0] cnt;
  int n_mismatch, comparisons, cycles;
  logic [7:0] rst_idx [7] = '{8'h28, 8'h29, 8'h2c, 8'h33, 8'h35, 8'h36, 8'h3a};
  logic [11:0] runs [4] = '{`LSD_RUN_E1_I431, `LSD_RUN_E1_G775, `LSD_RUN_T1_I431, `LSD_RUN_T1_ANSI};

  lsd_top #(.RUN_W(12)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_bit_valid(vld), .rx_amp_below(below),
    .rx_amp_above(above), .rx_mark(mark), .amplitude_threshold_sel(thr),
    .rx_data_out(dout), .rx_data_valid_out(dvalid), .signal_lost(signal_lost), .irq_n(irq_n));
  lsd_fe_model fe_u (.pclk(pclk), .presetn(presetn), .start(start), .count(cnt), .low(low),
    .slow(slow), .pattern(pat), .busy(fe_busy), .rx_bit_valid(vld), .rx_amp_below(below),
    .rx_amp_above(above), .rx_mark(mark));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Keep the data bit seen at each output strobe
  always @(posedge pclk) if (dvalid === 1'b1) last_out <= dout;
  // Hang guard well above the longest expected run
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; holds the request until pready is seen at an edge
  task automatic apb(input logic [7:0] idx, input logic wr, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    apb(idx, 1'b0, 32'h0);
    check(rd, exp);
  endtask
  task automatic settle();
    repeat (3) @(posedge pclk);
  endtask
  // Ask the front end for n intervals and wait until the detector has digested them
  task automatic send(input logic [11:0] n, input logic lo, input logic [31:0] p);
    int t = 0;
    @(posedge pclk);
    start <= 1'b1;
    cnt <= n;
    low <= lo;
    pat <= p;
    @(posedge pclk);
    start <= 1'b0;
    repeat (2) @(posedge pclk);
    while (fe_busy === 1'b1 && t < 5000) begin
      @(posedge pclk);
      t++;
    end
    repeat (4) @(posedge pclk);
  endtask
  task automatic pulse_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    {presetn, psel, penable, pwrite, start, low, slow} = 7'h00;
    paddr = 10'h000;
    pwdata = 32'h0;
    cnt = 12'h000;
    pat = 32'h0;
    n_mismatch = 0;
    comparisons = 0;
    cycles = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, access kinds and an unmapped word
    foreach (rst_idx[i]) rdchk(rst_idx[i], 32'h0);
    check({31'h0, irq_n}, 32'h1);
    apb(`LSD_IDX_RX_CFG1, 1'b1, 32'h15);
    rdchk(`LSD_IDX_RX_CFG1, 32'h15);
    check({27'h0, thr}, 32'h15);
    apb(`LSD_IDX_LINE_ST0, 1'b1, 32'h1);
    rdchk(`LSD_IDX_LINE_ST0, 32'h0);
    rdchk(8'h30, 32'h0);
    check({31'h0, last_err}, 32'h1);
    // Each mode and criterion: one interval short stays clear, full run declares
    foreach (runs[i]) begin
      pulse_reset();
      apb(`LSD_IDX_RX_MODE, 1'b1, {31'h0, i < 2});
      apb(`LSD_IDX_MAINT1, 1'b1, {31'h0, i % 2 == 0});
      send(runs[i] - 12'd1, 1'b1, 32'h0);
      check({31'h0, signal_lost}, 32'h0);
      send(12'd1, 1'b1, 32'h0);
      check({31'h0, signal_lost}, 32'h1);
    end
    // T1 hopping window: too few marks fails, exactly 16 clears
    send(12'd128, 1'b0, 32'h00000003);
    check({31'h0, signal_lost}, 32'h1);
    apb(`LSD_IDX_IRQ_CLR0, 1'b1, 32'h1);
    send(12'd128, 1'b0, 32'h01010101);
    check({31'h0, signal_lost}, 32'h0);
    rdchk(`LSD_IDX_IRQ_ST0, 32'h0);
    // E1: a good interval mid-run restarts the count
    pulse_reset();
    apb(`LSD_IDX_RX_MODE, 1'b1, 32'h1);
    apb(`LSD_IDX_IRQ_EN0, 1'b1, 32'h1);
    send(12'd31, 1'b1, 32'h0);
    send(12'd1, 1'b0, 32'h0);
    send(12'd31, 1'b1, 32'h0);
    check({31'h0, signal_lost}, 32'h0);
    send(12'd1, 1'b1, 32'h0);
    check({31'h0, signal_lost}, 32'h1);
    rdchk(`LSD_IDX_LINE_ST0, 32'h1);
    rdchk(`LSD_IDX_IRQ_ST0, 32'h1);
    check({31'h0, irq_n}, 32'h0);
    apb(`LSD_IDX_IRQ_CLR0, 1'b1, 32'h1);
    settle();
    check({31'h0, irq_n}, 32'h1);
    rdchk(`LSD_IDX_IRQ_ST0, 32'h0);
    // Marks with low amplitude never clear; ones inserted only with raise set
    send(12'd32, 1'b1, 32'h01010101);
    check({31'h0, last_out}, 32'h0);
    apb(`LSD_IDX_MAINT1, 1'b1, 32'h2);
    send(12'd32, 1'b1, 32'h01010101);
    check({31'h0, last_out}, 32'h1);
    check({31'h0, signal_lost}, 32'h1);
    // E1 windows: three marks fail, a 28-zero run fails, four spread marks clear
    send(12'd32, 1'b0, 32'h01001001);
    check({31'h0, signal_lost}, 32'h1);
    send(12'd32, 1'b0, 32'h0000000f);
    check({31'h0, signal_lost}, 32'h1);
    apb(`LSD_IDX_IRQ_EDGE, 1'b1, 32'h1);
    apb(`LSD_IDX_IRQ_EN0, 1'b1, 32'h0);
    slow <= 1'b1;
    send(12'd32, 1'b0, 32'h01010101);
    check({31'h0, signal_lost}, 32'h0);
    rdchk(`LSD_IDX_IRQ_ST0, 32'h1);
    check({31'h0, irq_n}, 32'h1);
    apb(`LSD_IDX_IRQ_EN0, 1'b1, 32'h1);
    settle();
    check({31'h0, irq_n}, 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
